/* File: src/tws_eeprom_port.sv */
`timescale 1ns/1ps
`include "tws_consts.svh"

module tws_eeprom_port
#(
   parameter int PROG_CYCLES = `TWS_PROG_TIME_NS / `TWS_CLK_PERIOD_NS
)
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Serial link from host, plus the word-width strap
   input  wire logic select,
   input  wire logic shift_clock,
   input  wire logic serial_in,
   input  wire logic word_width_strap,
   // Serial output pin
   output logic      serial_out,
   output logic      serial_out_oe
);
   // ---------------------------------------------------------------
   // Serial decoder state
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE, ST_OPC, ST_ADDR, ST_DATA, ST_READ, ST_STATUS, ST_HOLD
   } tws_state_e;

   tws_state_e         state;
   tws_state_e         next_state;
   logic               sel_q;
   logic               sk_q;
   logic [4:0]         bit_cnt;
   logic [4:0]         next_bit_cnt;
   logic [1:0]         opc;
   logic [1:0]         next_opc;
   logic [6:0]         addr;
   logic [6:0]         next_addr;
   logic [15:0]        data;
   logic [15:0]        next_data;
   logic [15:0]        shreg;
   logic [15:0]        next_shreg;
   logic               dout;
   logic               next_dout;
   logic               unlocked;
   logic               next_unlocked;
   logic               push_valid;
   tws_pkg::tws_prog_s push_req;
   logic               fifo_in_ready;

   // Engine side
   logic               fifo_out_valid;
   logic               fifo_out_ready;
   tws_pkg::tws_prog_s fifo_out;
   logic               eng_busy;
   logic               next_eng_busy;
   tws_pkg::tws_prog_s job;
   tws_pkg::tws_prog_s next_job;
   logic [31:0]        cnt;
   logic [31:0]        next_cnt;
   logic [7:0]         mem [`TWS_BYTES];
   logic [7:0]         next_mem [`TWS_BYTES];
   logic               busy;

   logic               sk_rise;
   logic               sel_rise;
   logic [6:0]         na;
   logic [15:0]        nd;
   logic [1:0]         sf;
   logic [4:0]         alen;
   logic [4:0]         dlen;

   assign sk_rise  = select & shift_clock & ~sk_q;
   assign sel_rise = select & ~sel_q;
   assign busy     = eng_busy | fifo_out_valid;
   assign na       = {addr[5:0], serial_in};
   assign nd       = {data[14:0], serial_in};
   assign alen     = word_width_strap ? `TWS_ADDR_BITS_X16 : `TWS_ADDR_BITS_X8;
   assign dlen     = word_width_strap ? `TWS_DATA_BITS_X16 : `TWS_DATA_BITS_X8;
   assign sf       = word_width_strap ? na[5:4] : na[6:5];

   assign serial_out    = dout;
   assign serial_out_oe = select;

   // ---------------------------------------------------------------
   // Instruction decoder
   // ---------------------------------------------------------------
   always_comb
   begin
      next_state    = state;
      next_bit_cnt  = bit_cnt;
      next_opc      = opc;
      next_addr     = addr;
      next_data     = data;
      next_shreg    = shreg;
      next_dout     = dout;
      next_unlocked = unlocked;
      push_valid    = 1'b0;
      push_req      = '{op: tws_pkg::PRG_WRITE, wide: word_width_strap, addr: na, data: nd};
      if (!select)
      begin
         next_state = ST_IDLE;
         next_dout  = 1'b0;
      end
      else if (sel_rise)
      begin
         // Status only visible while a cycle is still running; an idle
         // device keeps the line low until a read shifts data out
         next_state = busy ? ST_STATUS : ST_IDLE;
         next_dout  = 1'b0;
      end
      else
      begin
         case (state)
            ST_IDLE:
               if (sk_rise && serial_in)
               begin
                  next_state   = ST_OPC;
                  next_bit_cnt = `TWS_OPC_BITS - 5'h01;
               end
            ST_STATUS:
            begin
               next_dout = ~busy;
               if (sk_rise && serial_in && !busy)
               begin
                  next_state   = ST_OPC;
                  next_dout    = 1'b0;
                  next_bit_cnt = `TWS_OPC_BITS - 5'h01;
               end
            end
            ST_OPC:
               if (sk_rise)
               begin
                  next_opc     = {opc[0], serial_in};
                  next_bit_cnt = bit_cnt - 5'h01;
                  if (bit_cnt == 5'h00)
                  begin
                     next_state   = ST_ADDR;
                     next_bit_cnt = alen - 5'h01;
                  end
               end
            ST_ADDR:
               if (sk_rise)
               begin
                  next_addr    = na;
                  next_bit_cnt = bit_cnt - 5'h01;
                  if (bit_cnt == 5'h00)
                  begin
                     next_state = ST_HOLD;
                     case (opc)
                        `TWS_OPC_READ:
                        begin
                           next_state   = ST_READ;
                           next_dout    = 1'b0;
                           next_bit_cnt = dlen - 5'h01;
                           next_shreg   = word_width_strap
                                        ? {mem[{na[5:0], 1'b0}], mem[{na[5:0], 1'b1}]}
                                        : {mem[na], 8'h00};
                        end
                        `TWS_OPC_WRITE:
                        begin
                           next_state   = ST_DATA;
                           next_bit_cnt = dlen - 5'h01;
                        end
                        `TWS_OPC_ERASE:
                        begin
                           push_valid  = unlocked;
                           push_req.op = tws_pkg::PRG_ERASE;
                        end
                        default:
                           case (sf)
                              `TWS_SF_UNLOCK: next_unlocked = 1'b1;
                              `TWS_SF_LOCK:   next_unlocked = 1'b0;
                              `TWS_SF_ERASE_ALL:
                              begin
                                 push_valid  = unlocked;
                                 push_req.op = tws_pkg::PRG_ERASE_ALL;
                              end
                              default:
                              begin
                                 next_state   = ST_DATA;
                                 next_bit_cnt = dlen - 5'h01;
                              end
                           endcase
                     endcase
                  end
               end
            ST_DATA:
               if (sk_rise)
               begin
                  next_data    = nd;
                  next_bit_cnt = bit_cnt - 5'h01;
                  if (bit_cnt == 5'h00)
                  begin
                     next_state  = ST_HOLD;
                     push_valid  = unlocked;
                     // Address was complete before the data phase began
                     push_req.addr = addr;
                     push_req.op = (opc == `TWS_OPC_WRITE) ? tws_pkg::PRG_WRITE
                                                           : tws_pkg::PRG_FILL;
                  end
               end
            ST_READ:
               if (sk_rise)
               begin
                  next_dout  = shreg[15];
                  next_shreg = {shreg[14:0], 1'b0};
               end
            ST_HOLD:
               next_state = ST_HOLD;
            default:
               next_state = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state    <= ST_IDLE;
         sel_q    <= 1'b0;
         sk_q     <= 1'b0;
         bit_cnt  <= 5'h00;
         opc      <= 2'h0;
         addr     <= 7'h00;
         data     <= 16'h0000;
         shreg    <= 16'h0000;
         dout     <= 1'b0;
         unlocked <= `TWS_UNLOCK_RST;
      end
      else
      begin
         state    <= next_state;
         sel_q    <= select;
         sk_q     <= shift_clock;
         bit_cnt  <= next_bit_cnt;
         opc      <= next_opc;
         addr     <= next_addr;
         data     <= next_data;
         shreg    <= next_shreg;
         dout     <= next_dout;
         unlocked <= next_unlocked;
      end
   end

   // ---------------------------------------------------------------
   // Job queue between decoder and programming engine
   // ---------------------------------------------------------------
   tws_fifo
   #(
      .WIDTH ($bits(tws_pkg::tws_prog_s)),
      .DEPTH (`TWS_FIFO_DEPTH)
   )
   u_fifo
   (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_valid  (push_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (push_req),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out)
   );

   // Engine drains only when idle, so a long cycle stalls the queue
   assign fifo_out_ready = ~eng_busy;

   // ---------------------------------------------------------------
   // Self-timed programming engine
   // ---------------------------------------------------------------
   always_comb
   begin
      next_eng_busy = eng_busy;
      next_job      = job;
      next_cnt      = cnt;
      for (int i = 0; i < `TWS_BYTES; i++)
         next_mem[i] = mem[i];
      if (!eng_busy)
      begin
         if (fifo_out_valid)
         begin
            next_eng_busy = 1'b1;
            next_job      = fifo_out;
            next_cnt      = 32'(PROG_CYCLES - 1);
         end
      end
      else if (cnt != 32'h00000000)
         next_cnt = cnt - 32'h00000001;
      else
      begin
         // Commit at the end so the old word stays readable meanwhile
         next_eng_busy = 1'b0;
         case (job.op)
            tws_pkg::PRG_WRITE:
               if (job.wide)
               begin
                  next_mem[{job.addr[5:0], 1'b0}] = job.data[15:8];
                  next_mem[{job.addr[5:0], 1'b1}] = job.data[7:0];
               end
               else
                  next_mem[job.addr] = job.data[7:0];
            tws_pkg::PRG_ERASE:
               if (job.wide)
               begin
                  next_mem[{job.addr[5:0], 1'b0}] = `TWS_ERASED_BYTE;
                  next_mem[{job.addr[5:0], 1'b1}] = `TWS_ERASED_BYTE;
               end
               else
                  next_mem[job.addr] = `TWS_ERASED_BYTE;
            tws_pkg::PRG_FILL:
               for (int i = 0; i < `TWS_BYTES; i++)
                  next_mem[i] = (job.wide && !i[0]) ? job.data[15:8] : job.data[7:0];
            default:
               for (int i = 0; i < `TWS_BYTES; i++)
                  next_mem[i] = `TWS_ERASED_BYTE;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         eng_busy <= 1'b0;
         job      <= '0;
         cnt      <= 32'h00000000;
      end
      else
      begin
         eng_busy <= next_eng_busy;
         job      <= next_job;
         cnt      <= next_cnt;
      end
      // Array is nonvolatile: reset leaves its contents alone
      for (int i = 0; i < `TWS_BYTES; i++)
         mem[i] <= next_mem[i];
   end

endmodule // tws_eeprom_port

/* File: include/tws_consts.svh */
`ifndef TWS_CONSTS_SVH
`define TWS_CONSTS_SVH

// ---------------------------------------------------------------
// Array organization
// ---------------------------------------------------------------
`define TWS_BYTES          128
`define TWS_ADDR_BITS_X8   5'h07
`define TWS_ADDR_BITS_X16  5'h06
`define TWS_DATA_BITS_X8   5'h08
`define TWS_DATA_BITS_X16  5'h10
`define TWS_OPC_BITS       5'h02

// ---------------------------------------------------------------
// Opcodes and special-function selectors
// ---------------------------------------------------------------
`define TWS_OPC_SPECIAL    2'h0
`define TWS_OPC_WRITE      2'h1
`define TWS_OPC_READ       2'h2
`define TWS_OPC_ERASE      2'h3
`define TWS_SF_LOCK        2'h0
`define TWS_SF_FILL        2'h1
`define TWS_SF_ERASE_ALL   2'h2
`define TWS_SF_UNLOCK      2'h3

// ---------------------------------------------------------------
// Reset values and timing
// ---------------------------------------------------------------
`define TWS_ERASED_BYTE    8'hFF
`define TWS_UNLOCK_RST     1'b0
`define TWS_CLK_PERIOD_NS  10
`define TWS_PROG_TIME_NS   10000000
`define TWS_FIFO_DEPTH     8

`endif

/* File: include/tws_pkg.sv */
package tws_pkg;

   typedef enum logic [1:0] {
      PRG_WRITE,
      PRG_ERASE,
      PRG_FILL,
      PRG_ERASE_ALL
   } tws_prog_e;

   // One queued programming job
   typedef struct packed {
      tws_prog_e   op;
      logic        wide;
      logic [6:0]  addr;
      logic [15:0] data;
   } tws_prog_s;

endpackage

/* File: src/tws_fifo.sv */
`timescale 1ns/1ps

module tws_fifo
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
)
(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] store [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic [AW-1:0]    next_wr_ptr;
   logic [AW-1:0]    next_rd_ptr;
   logic [AW:0]      next_count;
   logic             push;
   logic             pop;

   assign in_ready  = (count != DEPTH[AW:0]);
   assign out_valid = (count != '0);
   assign out_data  = store[rd_ptr];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_comb
   begin
      next_wr_ptr = push ? ((wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
      next_rd_ptr = pop ? ((rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
      next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end
      else
      begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
      end
      // Storage needs no reset: entries are only read once written
      if (push)
         store[wr_ptr] <= in_data;
   end

endmodule // tws_fifo

/* File: tb/tws_host_model.sv */
`timescale 1ns/1ps

module tws_host_model
#(
   parameter int HALF = 25
)
(
   // Clock
   input  wire logic clk,
   // Serial link
   output logic      select,
   output logic      shift_clock,
   output logic      serial_in,
   input  wire logic serial_out
);
   initial
   begin
      select      = 1'b0;
      shift_clock = 1'b0;
      serial_in   = 1'b0;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(negedge clk);
   endtask

   // Half period of 25 clocks keeps the shift clock at 2 MHz
   task automatic frame(input logic [31:0] bits, input int n, input logic sel,
                        output logic [31:0] got);
      got    = '0;
      select = sel;
      wait_clk(2);
      for (int i = n - 1; i >= 0; i--)
      begin
         serial_in = bits[i];
         wait_clk(HALF);
         shift_clock = 1'b1;
         wait_clk(HALF);
         got         = {got[30:0], serial_out};
         shift_clock = 1'b0;
      end
      select    = 1'b0;
      serial_in = ~serial_in;
      wait_clk(HALF);
   endtask

   task automatic status(input int lim, output int n, output logic first);
      select = 1'b1;
      wait_clk(3);
      first = serial_out;
      n     = 0;
      while (serial_out !== 1'b1 && n < lim)
      begin
         wait_clk(1);
         n++;
      end
      select = 1'b0;
      wait_clk(HALF);
   endtask
endmodule // tws_host_model

/* File: tb/tws_eeprom_port_checker.sv */
`timescale 1ns/1ps

module tws_eeprom_port_checker
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Pins
   input wire logic select,
   input wire logic shift_clock,
   input wire logic serial_in,
   input wire logic word_width_strap,
   input wire logic serial_out,
   input wire logic serial_out_oe
);
   // ----------------
   // Bit tracking
   // ----------------
   logic       sk_q;
   logic [5:0] cnt;
   logic [1:0] op;
   logic       take;
   logic [5:0] hdr;
   logic [5:0] w;

   assign take = select && shift_clock && !sk_q;
   assign hdr  = word_width_strap ? 6'h09 : 6'h0A;
   assign w    = word_width_strap ? 6'h10 : 6'h08;

   // Leading zeros before the start bit are not counted
   always_ff @(posedge clk)
   begin
      sk_q <= shift_clock;
      if (!rst_n || !select)
      begin
         cnt <= 6'h00;
         op  <= 2'h0;
      end
      else if (take && (cnt != 6'h00 || serial_in) && cnt != 6'h3F)
      begin
         cnt <= cnt + 6'h01;
         if (cnt == 6'h01 || cnt == 6'h02)
            op <= {op[0], serial_in};
      end
   end

   // ----------------
   // Properties
   // ----------------
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   oe_track_a: assert property (serial_out_oe == select)
      else $error("output enable differs from select");
   desel_low_a: assert property (!select [*3] |-> !serial_out)
      else $error("output high while deselected");
   dummy_zero_a: assert property (take && op == 2'h2 && cnt == hdr - 6'h01 |-> ##2 !serial_out)
      else $error("dummy bit not zero");
   tail_zero_a: assert property (take && op == 2'h2 && cnt >= hdr + w |-> ##2 !serial_out)
      else $error("output not zero after the word");
   addr_quiet_a: assert property (select && op == 2'h2 && cnt >= 6'h03 && cnt < hdr |=> !serial_out)
      else $error("output active during address");
   prog_quiet_a: assert property (select && cnt >= 6'h03 && op != 2'h2 |=> !serial_out)
      else $error("output active in a non-read instruction");
   fall_cause_a: assert property (select && $past(select) && $past(select, 2) && $fell(serial_out)
                                  |-> $past(take))
      else $error("output fell without a shift edge");
   rise_cause_a: assert property (op == 2'h2 && cnt >= hdr && $rose(serial_out) |-> $past(take))
      else $error("read output rose without a shift edge");
endmodule // tws_eeprom_port_checker

bind tws_eeprom_port tws_eeprom_port_checker tws_eeprom_port_checker_inst (
   .clk(clk), .rst_n(rst_n), .select(select), .shift_clock(shift_clock),
   .serial_in(serial_in), .word_width_strap(word_width_strap),
   .serial_out(serial_out), .serial_out_oe(serial_out_oe));

/* File: tb/tws_eeprom_port_tb.sv */
`timescale 1ns/1ps
`include "tws_consts.svh"

module tws_eeprom_port_tb;
   localparam int PROG = 200;

   logic        clk      = 1'b0;
   logic        rst_n    = 1'b0;
   logic        strap    = 1'b0;
   logic        select;
   logic        shift_clock;
   logic        serial_in;
   logic        serial_out;
   logic        serial_out_oe;
   logic [31:0] r;
   logic        first;
   int          bn;
   int          failures = 0;
   int          checked  = 0;
   int          cycles   = 0;

   always #5 clk = ~clk;

   tws_eeprom_port #(.PROG_CYCLES(PROG)) tws_eeprom_port_inst (
      .clk(clk), .rst_n(rst_n), .select(select), .shift_clock(shift_clock),
      .serial_in(serial_in), .word_width_strap(strap), .serial_out(serial_out),
      .serial_out_oe(serial_out_oe));

   tws_host_model tws_host_model_inst (
      .clk(clk), .select(select), .shift_clock(shift_clock),
      .serial_in(serial_in), .serial_out(serial_out));

   task automatic test_done();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input logic [19:0] got, input logic [19:0] exp, input string msg);
      checked++;
      if (got !== exp)
      begin
         failures++;
         $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task automatic send(input logic [1:0] opc, input logic [6:0] a, input logic [15:0] d,
                       input int dn, output logic [31:0] got);
      int          an;
      logic [31:0] b;
      an = strap ? 6 : 7;
      b  = {30'h1, opc};
      b  = (b << an) | 32'(a);
      b  = (b << dn) | 32'(d);
      tws_host_model_inst.frame(b, 3 + an + dn, 1'b1, got);
   endtask

   // One extra shift past the word shows the trailing zero
   task automatic rd(input logic [6:0] a, input logic [15:0] d);
      send(`TWS_OPC_READ, a, 16'h0000, strap ? 17 : 9, r);
      chk(r[19:0], {3'h0, d, 1'b0}, "read word");
   endtask

   task automatic special(input logic [1:0] sf, input logic [15:0] d);
      send(`TWS_OPC_SPECIAL, strap ? {1'b0, sf, 4'h0} : {sf, 5'h00}, d,
           sf == `TWS_SF_FILL ? (strap ? 16 : 8) : 0, r);
   endtask

   task automatic wait_ready();
      tws_host_model_inst.status(PROG + 10, bn, first);
      chk(20'(first), 20'h00000, "busy status");
      chk(20'(bn > 0 && bn <= PROG), 20'h00001, "program time");
   endtask

   // ----------------
   // Scenarios
   // ----------------
   task automatic t_array();
      special(`TWS_SF_UNLOCK, 16'h0000);
      special(`TWS_SF_FILL, 16'h0081);
      wait_ready();
      rd(7'h00, 16'h0081);
      rd(7'h7F, 16'h0081);
      special(`TWS_SF_ERASE_ALL, 16'h0000);
      wait_ready();
      rd(7'h05, 16'h00FF);
      send(`TWS_OPC_WRITE, 7'h05, 16'h003C, 8, r);
      wait_ready();
      rd(7'h05, 16'h003C);
      send(`TWS_OPC_WRITE, 7'h05, 16'h00C3, 8, r);
      wait_ready();
      rd(7'h05, 16'h00C3);
      send(`TWS_OPC_ERASE, 7'h05, 16'h0000, 0, r);
      wait_ready();
      rd(7'h05, 16'h00FF);
   endtask

   task automatic t_lock();
      special(`TWS_SF_LOCK, 16'h0000);
      send(`TWS_OPC_WRITE, 7'h06, 16'h0012, 8, r);
      repeat (PROG + 10) @(negedge clk);
      rd(7'h06, 16'h00FF);
      rd(7'h00, 16'h00FF);
   endtask

   task automatic t_wide();
      special(`TWS_SF_UNLOCK, 16'h0000);
      strap = 1'b1;
      send(`TWS_OPC_WRITE, 7'h03, 16'hA55A, 16, r);
      wait_ready();
      rd(7'h03, 16'hA55A);
      strap = 1'b0;
      rd(7'h06, 16'h00A5);
      rd(7'h07, 16'h005A);
   endtask

   // A full write frame with select low must leave the word alone
   task automatic t_desel();
      tws_host_model_inst.frame({14'h0, 1'b1, 2'b01, 7'h07, 8'h00}, 18, 1'b0, r);
      repeat (PROG + 10) @(negedge clk);
      chk(20'(serial_out_oe), 20'h00000, "enable while deselected");
      rd(7'h07, 16'h005A);
   endtask

   initial
   begin
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      repeat (2) @(negedge clk);
      t_array();
      t_lock();
      t_wide();
      t_desel();
      test_done();
   end

   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 90000)
      begin
         failures++;
         $display("BAD %0t timeout", $time);
         test_done();
      end
   end
endmodule // tws_eeprom_port_tb
